//--- core/vfl_core.sv
/*
  Vector fault reporting and vector length control with a Wishbone slave.
  Assumes a memory pipeline presenting one element result per cycle and a
  classic Wishbone master on the same clock.
*/
// Summary of operation
// - Synchronous load/store fault writes class code by source level, then aborts.
// - Fault address gets lowest address of reported active element.
// - Among several faults any one may be reported; first seen wins here.
// - Faulted load or store restarts from beginning on return.
// - Faulting store: non-faulting active locations unknown, others kept.
// - Faulting normal load: destination unknown unless also base/index, kept.
// - Non-fault load never traps nor updates syndrome or addresses.
// - Fault or suppression clears predicate from element upward, never set.
// - Active false element bytes: zero, old, or memory if allowed.
// - Inactive false element: zero or previous value.
// - True element: memory value if active, zero if inactive.
// - First-fault load: first active element behaves as normal load.
// - Faults are translation, non-stack alignment, external aborts, watchpoints.
// - Reads of non-first active elements may be suppressed.
// - Interrupted vector instruction restarts, never resumes.
// - Powers of two below maximum always selectable lengths.
// - Unsupported request rounds down; stored field unchanged.
// - Length limit is field plus one times 128 bits.
// - Bits beyond reduced length are inaccessible.
// - Newly exposed bits read zero or earlier value.
// - Disabled level uses field zero except direct reads.
// - All lower levels disabled: target level state preserved.
// - Predicate reads and writes occur in program order.
`timescale 1ns/1ps
`include "vfl_defs.svh"
module vfl_core
  import vfl_pkg::*;
#(
  parameter int       ELEMS     = 64,
  parameter int       MAX_CODE  = 15,
  parameter bit [15:0] SUPPORTED = 16'h808b
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  output logic                  wb_ack_o,
  input  wire logic             op_start_i,
  input  wire vfl_kind_e        op_kind_i,
  input  wire vfl_op_s          op_info_i,
  input  wire vfl_elem_s        elem_i,
  input  wire logic             async_irq_i,
  output logic                  abort_o,
  output logic                  restart_o,
  output logic                  elem_unknown_o,
  output logic                  elem_keep_o,
  output logic                  elem_zero_o,
  output logic                  elem_use_mem_o,
  output logic      [ELEMS-1:0] ffr_o,
  output logic      [3:0]       eff_len_code_o,
  output logic      [ELEMS-1:0] access_mask_o,
  output logic                  preserve_state_o
);
  logic [3:0]  ctrl_len [1:3];
  logic [3:0]  level_en;
  logic [5:0]  syndrome_class;
  logic [63:0] fault_address_reg;
  logic        fault_seen;
  logic        fault_valid;
  logic        in_op;
  logic        first_pending;
  vfl_kind_e   kind;
  vfl_op_s     info;
  logic [3:0]  prev_len;
  logic        grow;

  initial
  begin
    if (MAX_CODE < 0 || MAX_CODE > 15 || ELEMS < 32 || ELEMS > 64)
    begin
      $error("vfl_core: unsupported parameters");
    end
  end

  // Fault classification
  wire is_first_active = first_pending && elem_i.active;
  wire ff_as_normal    = (kind == VFL_LD_FIRST_FAULT) && is_first_active;
  wire trapping        = (kind == VFL_LD_NORMAL) || (kind == VFL_ST) || ff_as_normal;
  wire elem_fault      = elem_i.valid && elem_i.active && elem_i.fault;
  wire nf_mode         = (kind == VFL_LD_NON_FAULT) || ((kind == VFL_LD_FIRST_FAULT) && !ff_as_normal);
  wire nf_drop         = elem_i.valid && elem_i.active && nf_mode
                         && (elem_i.fault || elem_i.suppressed || elem_i.device_mem);
  wire take_fault      = in_op && elem_fault && trapping && !fault_seen;
  wire same_level      = info.cur_level == info.target_level;
  wire [5:0] next_class = same_level ? `VFL_EC_SAME : `VFL_EC_LOWER;

  // Effective length per level
  logic [3:0] eff_code [1:3];
  genvar l;
  generate
    for (l = 1; l <= 3; l++)
    begin : g_lvl
      assign eff_code[l] = level_en[l] ? ctrl_len[l] : 4'h0;
    end
  endgenerate

  wire [1:0] cur_lvl  = op_info_i.cur_level;
  wire [3:0] req_lo   = (cur_lvl <= 2'd1) ? eff_code[1] : 4'hf;
  wire [3:0] req_mid  = (cur_lvl <= 2'd2 && eff_code[2] < req_lo) ? eff_code[2] : req_lo;
  wire [3:0] req_code = (eff_code[3] < req_mid) ? eff_code[3] : req_mid;
  wire [3:0] req_cap  = (req_code > 4'(MAX_CODE)) ? 4'(MAX_CODE) : req_code;

  // Round down to largest supported length
  logic [3:0] next_eff;
  always_comb
  begin
    next_eff = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (i <= int'(req_cap)
          && (SUPPORTED[i] || i == 0 || i == 1 || i == 3 || i == 7 || i == MAX_CODE))
      begin
        next_eff = 4'(i);
      end
    end
  end

  // Per-element accessibility mask
  genvar e;
  generate
    for (e = 0; e < ELEMS; e++)
    begin : g_acc
      assign access_mask_o[e] = e < ((int'(eff_len_code_o) + 1) * `VFL_GRAN_BITS / 8);
    end
  endgenerate

  // Wishbone decode
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr  = wb_req && wb_we_i && (&wb_sel_i);

  // Predicate storage
  vfl_ffr_mem #(.ELEMS(ELEMS)) u_ffr (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .set_all_i  (1'b0),
    .wr_i       (wb_wr && wb_adr_i == `VFL_OFF_FFR),
    .wdata_i    (ELEMS'({32'h0, wb_dat_i})),
    .clr_from_i (in_op && nf_drop),
    .clr_idx_i  (elem_i.index),
    .rdata_o    (ffr_o)
  );

  // Read selection
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (wb_adr_i)
      `VFL_OFF_CTRL1:    rd_mux = {28'h0, ctrl_len[1]};
      `VFL_OFF_CTRL2:    rd_mux = {28'h0, ctrl_len[2]};
      `VFL_OFF_CTRL3:    rd_mux = {28'h0, ctrl_len[3]};
      `VFL_OFF_ENABLE:   rd_mux = {28'h0, level_en};
      `VFL_OFF_EFF_LEN:  rd_mux = {28'h0, eff_len_code_o};
      `VFL_OFF_SYNDROME: rd_mux = {26'h0, syndrome_class};
      `VFL_OFF_FAR_LO:   rd_mux = fault_address_reg[31:0];
      `VFL_OFF_FAR_HI:   rd_mux = fault_address_reg[63:32];
      `VFL_OFF_FFR:      rd_mux = ffr_o[31:0];
      `VFL_OFF_STATUS:   rd_mux = {30'h0, in_op, fault_valid};
      default:           rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0;
    end
  end

  // Configuration registers; stored field kept as written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_len[1] <= 4'h0;
      ctrl_len[2] <= 4'h0;
      ctrl_len[3] <= 4'h0;
      level_en    <= `VFL_ENABLE_RESET;
    end
    else if (wb_wr)
    begin
      if (wb_adr_i == `VFL_OFF_CTRL1) ctrl_len[1] <= wb_dat_i[3:0];
      if (wb_adr_i == `VFL_OFF_CTRL2) ctrl_len[2] <= wb_dat_i[3:0];
      if (wb_adr_i == `VFL_OFF_CTRL3) ctrl_len[3] <= wb_dat_i[3:0];
      if (wb_adr_i == `VFL_OFF_ENABLE) level_en <= wb_dat_i[3:0];
    end
  end

  // Effective length and growth tracking
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      eff_len_code_o <= 4'h0;
      prev_len       <= 4'h0;
      grow           <= 1'b0;
    end
    else
    begin
      eff_len_code_o <= next_eff;
      prev_len       <= eff_len_code_o;
      grow           <= eff_len_code_o > prev_len;
    end
  end

  // Exposed bits keep earlier value; nothing is cleared on growth
  assign preserve_state_o = grow || (level_en[2:0] == 3'b000);

  // Operation tracking
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_op         <= 1'b0;
      first_pending <= 1'b0;
      kind          <= VFL_LD_NORMAL;
      info          <= '0;
      fault_seen    <= 1'b0;
    end
    else if (op_start_i)
    begin
      in_op         <= 1'b1;
      first_pending <= 1'b1;
      kind          <= op_kind_i;
      info          <= op_info_i;
      fault_seen    <= 1'b0;
    end
    else if (in_op)
    begin
      if (elem_i.valid && elem_i.active)
      begin
        first_pending <= 1'b0;
      end
      if (take_fault || async_irq_i || (elem_i.valid && elem_i.last))
      begin
        in_op <= 1'b0;
      end
      if (take_fault)
      begin
        fault_seen <= 1'b1;
      end
    end
  end

  // Syndrome and fault address, never touched by non-fault loads
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      syndrome_class    <= 6'h0;
      fault_address_reg <= `VFL_FAR_RESET;
      fault_valid       <= 1'b0;
    end
    else if (take_fault)
    begin
      syndrome_class    <= next_class;
      fault_address_reg <= elem_i.low_addr;
      fault_valid       <= 1'b1;
    end
    else if (wb_wr && wb_adr_i == `VFL_OFF_STATUS && wb_dat_i[0])
    begin
      fault_valid <= 1'b0;
    end
  end

  // Abort and restart pulses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      abort_o   <= 1'b0;
      restart_o <= 1'b0;
    end
    else
    begin
      abort_o   <= take_fault;
      restart_o <= take_fault || (in_op && async_irq_i);
    end
  end

  // Per-element destination policy
  wire st_kind = (kind == VFL_ST);
  wire ld_trap = (kind == VFL_LD_NORMAL) || ff_as_normal;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      elem_unknown_o <= 1'b0;
      elem_keep_o    <= 1'b0;
      elem_zero_o    <= 1'b0;
      elem_use_mem_o <= 1'b0;
    end
    else
    begin
      elem_unknown_o <= elem_i.valid && ((st_kind && elem_i.active && !elem_i.fault)
                        || (ld_trap && elem_fault && !info.dest_is_base));
      elem_keep_o    <= elem_i.valid && ((st_kind && (!elem_i.active || elem_i.fault))
                        || (ld_trap && elem_fault && info.dest_is_base)
                        || (nf_mode && elem_i.active && nf_drop));
      elem_zero_o    <= elem_i.valid && !elem_i.active && !st_kind;
      elem_use_mem_o <= elem_i.valid && elem_i.active && !st_kind && !elem_fault
                        && !nf_drop && elem_i.priv_ok;
    end
  end
endmodule

//--- core/vfl_ffr_mem.sv
/*
  First-fault predicate storage, one bit per element, registered read.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module vfl_ffr_mem #(
  parameter int ELEMS = 64
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             set_all_i,
  input  wire logic             wr_i,
  input  wire logic [ELEMS-1:0] wdata_i,
  input  wire logic             clr_from_i,
  input  wire logic [5:0]       clr_idx_i,
  output logic      [ELEMS-1:0] rdata_o
);
  logic [ELEMS-1:0] bits;
  logic [ELEMS-1:0] clr_mask;

  initial
  begin
    if (ELEMS < 1 || ELEMS > 64)
    begin
      $error("vfl_ffr_mem: ELEMS out of range");
    end
  end

  // Mask of element index and above
  genvar g;
  generate
    for (g = 0; g < ELEMS; g++)
    begin : g_mask
      assign clr_mask[g] = clr_from_i && (6'(g) >= clr_idx_i);
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bits <= '1;
    end
    else if (set_all_i)
    begin
      bits <= '1;
    end
    else if (wr_i)
    begin
      bits <= wdata_i;
    end
    else
    begin
      bits <= bits & ~clr_mask;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= '1;
    end
    else
    begin
      rdata_o <= bits;
    end
  end
endmodule

//--- inc/vfl_defs.svh
/*
  Constants for the vector fault and length control block.
  Assumes inclusion by bare name from the inc folder.
*/
`ifndef VFL_DEFS_SVH
`define VFL_DEFS_SVH

`define VFL_EC_LOWER      6'h24
`define VFL_EC_SAME       6'h25
`define VFL_GRAN_BITS     128
`define VFL_MAX_LEN_CODE  4'hf
`define VFL_OFF_CTRL1     8'h00
`define VFL_OFF_CTRL2     8'h04
`define VFL_OFF_CTRL3     8'h08
`define VFL_OFF_ENABLE    8'h0c
`define VFL_OFF_EFF_LEN   8'h10
`define VFL_OFF_SYNDROME  8'h14
`define VFL_OFF_FAR_LO    8'h18
`define VFL_OFF_FAR_HI    8'h1c
`define VFL_OFF_FFR       8'h20
`define VFL_OFF_STATUS    8'h24
`define VFL_FAR_RESET     64'h0
`define VFL_ENABLE_RESET  4'h0

`endif

//--- inc/vfl_pkg.sv
/*
  Types for the vector fault and length control block.
  Assumes vfl_defs.svh is available on the include path.
*/
package vfl_pkg;

  typedef enum logic [1:0] {VFL_LD_NORMAL, VFL_LD_FIRST_FAULT, VFL_LD_NON_FAULT, VFL_ST} vfl_kind_e;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic [5:0]  index;
    logic        active;
    logic        fault;
    logic        suppressed;
    logic        device_mem;
    logic        priv_ok;
    logic [63:0] low_addr;
  } vfl_elem_s;

  typedef struct packed {
    logic [1:0] cur_level;
    logic [1:0] target_level;
    logic       dest_is_base;
  } vfl_op_s;

endpackage

//--- tb/vfl_core_bench.sv
/*
  Self-checking bench for vfl_core: registers, element streams, lengths.
  Assumes vfl_mem_model as memory side and vfl_core_chk bound to the core.
*/
`timescale 1ns/1ps
`include "vfl_defs.svh"
module vfl_core_bench
  import vfl_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, irq = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dwr = 32'h0, rdat, q;
  logic [3:0]  act = 4'h0, flt = 4'h0, sup = 4'h0, eff;
  logic [3:0]  pol [4];
  logic        ack, st, ab, rs, pu, pk, pz, pm, ps;
  logic [63:0] ffr, mask;
  vfl_kind_e   kind = VFL_LD_NORMAL;
  vfl_op_s     info = '0;
  vfl_elem_s   elem, ev;
  int          failures = 0, checks_done = 0, aborts = 0, restarts = 0, cycles = 0;
  logic [3:0]  lreq [6] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'he, 4'hf};
  logic [3:0]  lexp [6] = '{4'h1, 4'h3, 4'h5, 4'h5, 4'h7, 4'hf};

  always #2 clk_i = ~clk_i;

  vfl_core #(.SUPPORTED(16'h0020)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dwr), .wb_dat_o(rdat), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .op_start_i(st), .op_kind_i(kind),
    .op_info_i(info), .elem_i(elem), .async_irq_i(irq), .abort_o(ab), .restart_o(rs),
    .elem_unknown_o(pu), .elem_keep_o(pk), .elem_zero_o(pz), .elem_use_mem_o(pm), .ffr_o(ffr),
    .eff_len_code_o(eff), .access_mask_o(mask), .preserve_state_o(ps));
  vfl_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .act_i(act), .flt_i(flt), .sup_i(sup),
    .op_start_o(st), .elem_o(elem));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), q & m, e);
  endtask

  task automatic op(input vfl_kind_e k, input logic [1:0] cl, input logic [1:0] tl, input logic db,
                    input logic [3:0] a, input logic [3:0] f, input logic [3:0] s, input logic i);
    @(posedge clk_i);
    kind <= k;
    info <= '{cur_level: cl, target_level: tl, dest_is_base: db};
    act <= a;
    flt <= f;
    sup <= s;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
    irq <= i;
    @(posedge clk_i);
    irq <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic fchk(input logic [5:0] ec, input logic [31:0] fa, input int n);
    rdc(`VFL_OFF_SYNDROME, 32'h3f, {26'h0, ec});
    rdc(`VFL_OFF_FAR_LO, '1, fa);
    rdc(`VFL_OFF_FAR_HI, '1, 32'h0);
    rdc(`VFL_OFF_STATUS, 32'h1, 32'h1);
    chk("aborts", aborts, n);
    wb(1'b1, `VFL_OFF_STATUS, 32'h1);
  endtask

  function automatic logic [63:0] mexp(input logic [3:0] c);
    mexp = (c >= 4'h3) ? '1 : (64'h1 << ((c + 1) * 16)) - 64'h1;
  endfunction

  // Event counts and per-element destination policy
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    aborts <= aborts + int'(ab);
    restarts <= restarts + int'(rs);
    ev <= elem;
    if (ev.valid === 1'b1)
      pol[ev.index[1:0]] <= {pu, pk, pz, pm};
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("ffr", ffr, '1);
    chk("eff", eff, 64'h0);
    chk("preserve", ps, 64'h1);
    rdc(`VFL_OFF_STATUS, 32'h3, 32'h0);
    rdc(8'h3c, '1, 32'h0);
    op(VFL_LD_NON_FAULT, 0, 1, 0, 4'hd, 4'h0, 4'h4, 0);
    chk("ffr", ffr, 64'h3);
    chk("pol0", pol[0][0], 1);
    chk("pol1", pol[1][1], 1);
    op(VFL_LD_NON_FAULT, 0, 1, 0, 4'hf, 4'h2, 4'h0, 0);
    chk("ffr", ffr, 64'h1);
    chk("aborts", aborts, 0);
    rdc(`VFL_OFF_SYNDROME, '1, 32'h0);
    rdc(`VFL_OFF_FAR_LO, '1, 32'h0);
    wb(1'b1, `VFL_OFF_FFR, '1);
    op(VFL_LD_FIRST_FAULT, 0, 1, 0, 4'hf, 4'h4, 4'h0, 0);
    chk("ffr", ffr[31:0], 32'h3);
    chk("aborts", aborts, 0);
    op(VFL_LD_NORMAL, 1, 1, 0, 4'hf, 4'h6, 4'h0, 0);
    fchk(6'h25, 32'h1008, 1);
    chk("pol1", pol[1][3], 1);
    chk("restarts", restarts, 1);
    op(VFL_LD_NORMAL, 0, 1, 1, 4'hf, 4'h1, 4'h0, 0);
    fchk(6'h24, 32'h1000, 2);
    chk("pol0", pol[0][2], 1);
    op(VFL_ST, 0, 1, 0, 4'hb, 4'h2, 4'h0, 0);
    fchk(6'h24, 32'h1008, 3);
    chk("pol1", pol[1][2], 1);
    op(VFL_LD_FIRST_FAULT, 0, 1, 0, 4'hf, 4'h1, 4'h0, 0);
    fchk(6'h24, 32'h1000, 4);
    op(VFL_LD_NORMAL, 0, 0, 0, 4'hf, 4'h0, 4'h0, 1);
    chk("restarts", restarts, 5);
    chk("aborts", aborts, 4);
    wb(1'b1, `VFL_OFF_ENABLE, 32'hf);
    foreach (lreq[j])
    begin
      for (int r = 0; r < 3; r++)
        wb(1'b1, 8'(4 * r), {28'h0, lreq[j]});
      repeat (3) @(posedge clk_i);
      chk("eff", eff, lexp[j]);
      chk("mask", mask, mexp(lexp[j]));
      rdc(`VFL_OFF_CTRL1, 32'hf, {28'h0, lreq[j]});
      rdc(`VFL_OFF_EFF_LEN, 32'hf, {28'h0, lexp[j]});
    end
    wb(1'b1, `VFL_OFF_ENABLE, 32'hb);
    repeat (3) @(posedge clk_i);
    chk("eff", eff, 64'h0);
    rdc(`VFL_OFF_CTRL2, 32'hf, 32'hf);
    chk("preserve", ps, 64'h0);
    test_done();
  end
endmodule

//--- tb/vfl_core_chk.sv
/*
  Port checker for vfl_core.
  Assumes one clock and a synchronous active-high reset; bound to every core.
*/
`timescale 1ns/1ps
module vfl_core_chk
  import vfl_pkg::*;
#(
  parameter int        ELEMS     = 64,
  parameter int        MAX_CODE  = 15,
  parameter bit [15:0] SUPPORTED = 16'h808b
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             op_start_i,
  input wire vfl_kind_e        op_kind_i,
  input wire vfl_elem_s        elem_i,
  input wire logic             abort_o,
  input wire logic             restart_o,
  input wire logic [ELEMS-1:0] ffr_o,
  input wire logic [3:0]       eff_len_code_o,
  input wire logic [ELEMS-1:0] access_mask_o
);
  logic             nf;
  logic [ELEMS-1:0] exp_mask;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Last started op is a non-fault load; held after it ends
  always_ff @(posedge clk_i)
    if (rst_i)
      nf <= 1'b0;
    else if (op_start_i)
      nf <= op_kind_i == VFL_LD_NON_FAULT;
  always_comb
    for (int e = 0; e < ELEMS; e++)
      exp_mask[e] = e < (int'(eff_len_code_o) + 1) * 16;
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data while idle");
  a_abort_cause: assert property (abort_o |-> $past(elem_i.valid) && $past(elem_i.fault))
    else $error("abort without faulting element");
  a_abort_restart: assert property (abort_o |-> restart_o)
    else $error("abort without restart");
  a_nf_no_trap: assert property (nf |-> !abort_o)
    else $error("non-fault load trapped");
  a_ffr_no_set: assert property (!wb_cyc_i && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) && !$past(wb_cyc_i, 3)
    && !$past(rst_i) && !$past(rst_i, 2) |-> (ffr_o & ~$past(ffr_o)) == '0)
    else $error("predicate bit set by a load");
  a_len_legal: assert property (eff_len_code_o <= MAX_CODE && (SUPPORTED[eff_len_code_o]
    || eff_len_code_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf}))
    else $error("unsupported effective length");
  a_mask_len: assert property (access_mask_o == exp_mask)
    else $error("access mask disagrees with length");
endmodule

bind vfl_core vfl_core_chk #(.ELEMS(ELEMS), .MAX_CODE(MAX_CODE), .SUPPORTED(SUPPORTED)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .op_start_i(op_start_i), .op_kind_i(op_kind_i), .elem_i(elem_i),
  .abort_o(abort_o), .restart_o(restart_o), .ffr_o(ffr_o), .eff_len_code_o(eff_len_code_o),
  .access_mask_o(access_mask_o));

//--- tb/vfl_mem_model.sv
/*
  Memory-side model: starts one vector op and returns four element results.
  Assumes the bench drives the op kind and levels of the core itself.
*/
`timescale 1ns/1ps
module vfl_mem_model
  import vfl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] act_i,
  input  wire logic [3:0] flt_i,
  input  wire logic [3:0] sup_i,
  output logic            op_start_o,
  output vfl_elem_s       elem_o
);
  logic [2:0] nxt;
  logic [2:0] k;
  vfl_elem_s  nx;
  initial elem_o = '0;
  always @(posedge clk_i)
  begin
    k = op_start_o ? 3'd0 : nxt;
    // Idle stream toggles every cycle
    nx = ~elem_o;
    nx.valid = 1'b0;
    if (!rst_i && k < 3'd4)
    begin
      nx.valid      = 1'b1;
      nx.last       = k == 3'd3;
      nx.index      = {3'd0, k};
      nx.active     = act_i[k[1:0]];
      nx.fault      = flt_i[k[1:0]];
      nx.suppressed = sup_i[k[1:0]];
      nx.device_mem = 1'b0;
      nx.priv_ok    = 1'b1;
      nx.low_addr   = {58'h40, k, 3'h0};
    end
    op_start_o <= go_i;
    elem_o     <= nx;
    nxt        <= rst_i ? 3'd4 : ((k < 3'd4) ? k + 3'd1 : k);
  end
endmodule
